//--- core/irq_bank_consts.vh
// Purpose: Constants for the interrupt request-flag and enable bank
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes:   Masks give the implemented bits of each byte-wide register
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PRIMARY_IRQ_CTRL_2 8'h00
`define OFS_PRIMARY_IRQ_CTRL_3 8'h04
`define OFS_MULTI_IRQ_GROUP_0  8'h08
`define OFS_GLOBAL_CTRL        8'h28
`define OFS_EVENT_STATUS       8'h2C
`define OFS_EVENT_MASK         8'h30

// ----------------------------------------------------------------
// Bank layout
// ----------------------------------------------------------------
`define BANK_REGS       10
`define IDX_CTRL_2      4'h0
`define IDX_CTRL_3      4'h1
`define IDX_GLOBAL      4'hA
`define IDX_STATUS      4'hB
`define IDX_MASK        4'hC
`define IDX_NONE        4'hF
`define FLAG_LSB        4
`define BYTE_RESET      8'h00
`define WORD_ZERO       32'h00000000

// Implemented bits per register, bank index order
`define MASK_FULL       8'hFF
`define MASK_TWO_PAIRS  8'h33
`define MASK_THREE      8'h77

// Global control and event status fields
`define GLOBAL_EN_BIT   0
`define EVT_FLAG_RISE   0
`define EVT_SERVICED    1
`define EVT_WIDTH       2

`endif

//--- core/irq_flag_bank.v
// Purpose: Byte-wide interrupt request-flag and enable bank on AHB-Lite
// Assumes: Event inputs are one-cycle pulses from logic on REF_CLK
// Notes:   Reads take one wait state so read data comes from a flip-flop
//
// Overview of operation
// - Ctrl 2 holds flags of groups 3,9,8,2 in bits 7-4, enables in 3-0.
// - Ctrl 3 holds group 5,4 and pin 3,2 flags high, enables low.
// - Group 0 holds std timer 0 and periodic timer 0 match flags and enables.
// - Group 1 repeats group 0 layout for timers 1.
// - Group 2 holds periodic timer 2 flags in 5-4, enables 1-0 only.
// - Group 3 holds serial, SPI, EEPROM, low-voltage flags and enables.
// - Group 4 holds std timer 2 and periodic timer 3 flags and enables.
// - Group 5 holds UART1, UART0 flags in 5-4, enables 1-0.
// - Group 6 holds comparator 0 and periodic timer 4 flags and enables.
// - Group 7 holds comparator 1 and periodic timer 5 flags and enables.
// - Flags read 1 while pending and are software writable.
// - Enable bit 1 permits the source interrupt, 0 blocks it.
// - Unimplemented bits read zero, ignore writes; all bits reset to zero.
// - Global enable at zero suppresses IRQ_VECTOR_REQ; GROUP_REQ and IRQ are not gated by it.
// - Flags still set with enable clear; no vector request results.
// - Service clears global enable; new events still latch in flags.
// - Any flag becoming set wakes the device; preset flags do not.
`timescale 1ns/1ps
`include "irq_bank_consts.vh"

module irq_flag_bank (
	// Clock and reset
	input  wire        REF_CLK,
	input  wire        SRST,
	// AHB-Lite slave
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output wire [31:0] HRDATA,
	output wire        HREADYOUT,
	output wire        HRESP,
	// Source events, one-cycle pulses
	input  wire [2:0]  STD_TIMER_A_EVT,
	input  wire [2:0]  STD_TIMER_P_EVT,
	input  wire [5:0]  PER_TIMER_A_EVT,
	input  wire [5:0]  PER_TIMER_P_EVT,
	input  wire        SERIAL_EVT,
	input  wire        SPI_EVT,
	input  wire        EEPROM_EVT,
	input  wire        LVD_EVT,
	input  wire [1:0]  UART_EVT,
	input  wire [1:0]  COMP_EVT,
	input  wire [1:0]  EXT_PIN_EVT,
	input  wire [1:0]  GROUP_8_9_REQ,
	// Core side
	input  wire        SERVICE_ACK,
	output wire        IRQ_VECTOR_REQ,
	output wire [7:0]  GROUP_REQ,
	output wire        WAKE_PULSE,
	output wire        IRQ
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Maps a byte address to a register index, IDX_NONE when unmapped
	function [3:0] reg_index;
		input [31:0] addr;
		begin
			if (addr[31:8] != 24'h000000 || addr[1:0] != 2'h0 || addr[7:2] > 6'h0C)
				reg_index = `IDX_NONE;
			else
				reg_index = addr[5:2];
		end
	endfunction

	// Any flag that is pending with its enable set
	function grp_any;
		input [7:0] b;
		begin
			grp_any = |(b[7:4] & b[3:0]);
		end
	endfunction

	reg  [7:0]  bank_reg [0:`BANK_REGS-1];
	reg         global_en_reg;
	reg  [`EVT_WIDTH-1:0] status_reg;
	reg  [`EVT_WIDTH-1:0] mask_reg;
	reg  [31:0] rdata_reg;
	reg         ready_reg;
	reg         resp_reg;
	reg         wr_pend_reg;
	reg         rd_pend_reg;
	reg  [3:0]  idx_reg;
	reg         vec_req_reg;
	reg  [7:0]  group_req_reg;
	reg         wake_reg;
	reg         irq_reg;

	wire        addr_take;
	wire [3:0]  addr_idx;
	wire [79:0] bank_mask;
	wire [39:0] evt_vec;
	wire [7:0]  bank_next [0:`BANK_REGS-1];
	wire [`BANK_REGS-1:0] flag_rise;
	wire [`BANK_REGS-1:0] any_req;
	reg  [31:0] rd_mux;
	integer     k;

	// Address phase accepted only while the bus is ready
	assign addr_take = HSEL & HTRANS[1] & HREADY;
	assign addr_idx  = reg_index(HADDR);

	// ----------------------------------------------------------------
	// Bank registers
	// ----------------------------------------------------------------

	// Implemented bits, index 9 down to 0
	assign bank_mask = {`MASK_THREE, `MASK_THREE, `MASK_TWO_PAIRS, `MASK_FULL,
		`MASK_FULL, `MASK_TWO_PAIRS, `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL};

	// Flag-set events per register, flag order bit 7 down to 4
	assign evt_vec = {
		1'b0, COMP_EVT[1], PER_TIMER_A_EVT[5], PER_TIMER_P_EVT[5],
		1'b0, COMP_EVT[0], PER_TIMER_A_EVT[4], PER_TIMER_P_EVT[4],
		2'h0, UART_EVT[1], UART_EVT[0],
		STD_TIMER_A_EVT[2], STD_TIMER_P_EVT[2], PER_TIMER_A_EVT[3], PER_TIMER_P_EVT[3],
		SERIAL_EVT, SPI_EVT, EEPROM_EVT, LVD_EVT,
		2'h0, PER_TIMER_A_EVT[2], PER_TIMER_P_EVT[2],
		STD_TIMER_A_EVT[1], STD_TIMER_P_EVT[1], PER_TIMER_A_EVT[1], PER_TIMER_P_EVT[1],
		STD_TIMER_A_EVT[0], STD_TIMER_P_EVT[0], PER_TIMER_A_EVT[0], PER_TIMER_P_EVT[0],
		grp_any(bank_reg[7]), grp_any(bank_reg[6]), EXT_PIN_EVT[1], EXT_PIN_EVT[0],
		grp_any(bank_reg[5]), GROUP_8_9_REQ[1], GROUP_8_9_REQ[0], grp_any(bank_reg[4])
	};

	// Each register: write, then OR in events so a set beats a same-cycle clear
	genvar g;
	generate
		for (g = 0; g < `BANK_REGS; g = g + 1) begin : bank
			wire wr_hit;
			assign wr_hit = wr_pend_reg & (idx_reg == g);
			assign bank_next[g] = ((wr_hit ? HWDATA[7:0] : bank_reg[g])
				| {evt_vec[g*4 +: 4], 4'h0}) & bank_mask[g*8 +: 8];
			assign flag_rise[g] = |(bank_next[g][7:4] & ~bank_reg[g][7:4]);
			assign any_req[g]   = grp_any(bank_reg[g]);
		end
	endgenerate

	// One process owns the whole array, so no element has a second driver
	always @(posedge REF_CLK) begin
		for (k = 0; k < `BANK_REGS; k = k + 1) begin
			if (SRST)
				bank_reg[k] <= `BYTE_RESET;
			else
				bank_reg[k] <= bank_next[k];
		end
	end

	// ----------------------------------------------------------------
	// Global enable and core requests
	// ----------------------------------------------------------------

	// Service clear wins over a software write in the same cycle
	always @(posedge REF_CLK) begin
		if (SRST)
			global_en_reg <= 1'b0;
		else if (SERVICE_ACK)
			global_en_reg <= 1'b0;
		else if (wr_pend_reg && idx_reg == `IDX_GLOBAL)
			global_en_reg <= HWDATA[`GLOBAL_EN_BIT];
	end

	// Vector request only from the primary bits, gated by the global enable
	always @(posedge REF_CLK) begin
		if (SRST) begin
			vec_req_reg   <= 1'b0;
			group_req_reg <= 8'h00;
			wake_reg      <= 1'b0;
		end else begin
			vec_req_reg   <= global_en_reg & (any_req[`IDX_CTRL_2] | any_req[`IDX_CTRL_3])
				& ~SERVICE_ACK;
			group_req_reg <= any_req[9:2];
			wake_reg      <= |flag_rise;
		end
	end

	// ----------------------------------------------------------------
	// Event status, mask and interrupt output
	// ----------------------------------------------------------------

	// Read of the status register clears it; a new event beats the clear
	always @(posedge REF_CLK) begin
		if (SRST) begin
			status_reg <= {`EVT_WIDTH{1'b0}};
			mask_reg   <= {`EVT_WIDTH{1'b0}};
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= ((rd_pend_reg && idx_reg == `IDX_STATUS) ? {`EVT_WIDTH{1'b0}} : status_reg)
				| {SERVICE_ACK, |flag_rise};
			if (wr_pend_reg && idx_reg == `IDX_MASK)
				mask_reg <= HWDATA[`EVT_WIDTH-1:0];
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------

	// Read mux, unmapped addresses read zero
	always @* begin
		rd_mux = `WORD_ZERO;
		if (idx_reg < `BANK_REGS)
			rd_mux[7:0] = bank_reg[idx_reg];
		else if (idx_reg == `IDX_GLOBAL)
			rd_mux[`GLOBAL_EN_BIT] = global_en_reg;
		else if (idx_reg == `IDX_STATUS)
			rd_mux[`EVT_WIDTH-1:0] = status_reg;
		else if (idx_reg == `IDX_MASK)
			rd_mux[`EVT_WIDTH-1:0] = mask_reg;
	end

	// Writes complete at once; reads insert one wait state, then hold data
	always @(posedge REF_CLK) begin
		if (SRST) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			idx_reg     <= `IDX_NONE;
			ready_reg   <= 1'b1;
			resp_reg    <= 1'b0;
			rdata_reg   <= `WORD_ZERO;
		end else begin
			resp_reg <= 1'b0;                                                             // Always OKAY
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				ready_reg   <= 1'b1;
				rdata_reg   <= rd_mux;
			end else begin
				wr_pend_reg <= addr_take & HWRITE;
				rd_pend_reg <= addr_take & ~HWRITE;
				ready_reg   <= ~(addr_take & ~HWRITE);
				if (addr_take)
					idx_reg <= addr_idx;
			end
		end
	end

	assign HRDATA         = rdata_reg;
	assign HREADYOUT      = ready_reg;
	assign HRESP          = resp_reg;
	assign IRQ_VECTOR_REQ = vec_req_reg;
	assign GROUP_REQ      = group_req_reg;
	assign WAKE_PULSE     = wake_reg;
	assign IRQ            = irq_reg;

endmodule

//--- verification/event_source_model.sv
// Purpose: Peripheral event sources facing the flag bank
// Assumes: The bench requests events for one cycle at a time
// Notes:   Each pulse lasts exactly one clock, as the real sources give
`timescale 1ns/1ps
module event_source_model (
	// Clock
	input  wire        clk,
	// Bench request in, event pulses out
	input  wire [27:0] fire,
	output reg  [27:0] evt = 28'h0000000
);
	// Registered so each pulse starts just after an edge
	always @(posedge clk) begin
		evt <= fire;
	end
endmodule

//--- verification/irq_flag_bank_checker.sv
// Purpose: Port-level checks of the interrupt flag bank
// Assumes: One clock domain, reset synchronous and active high
// Notes:   Reserved-bit checks need reads of those registers
`timescale 1ns/1ps
module irq_flag_bank_checker (
	// Clock and reset
	input wire        REF_CLK,
	input wire        SRST,
	// Bus
	input wire        HSEL,
	input wire [31:0] HADDR,
	input wire [1:0]  HTRANS,
	input wire        HWRITE,
	input wire        HREADY,
	input wire [31:0] HRDATA,
	input wire        HREADYOUT,
	input wire        HRESP,
	// Core side
	input wire        SERVICE_ACK,
	input wire        IRQ_VECTOR_REQ,
	input wire [7:0]  GROUP_REQ,
	input wire        WAKE_PULSE,
	input wire        IRQ
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// Taken address phases
	wire rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
	wire wr_go = HSEL && HTRANS[1] && HREADY && HWRITE;
	// A read answers after exactly one wait state
	sequence rd_answer;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	property rd_zero(lo, hi, keep);
		rd_go && HADDR >= lo && HADDR <= hi |=> rd_answer ##0 (HRDATA[7:0] & ~keep) == 8'h00;
	endproperty
	reset_clear_a: assert property (disable iff (1'b0) SRST |=> HRDATA == 32'h0 && HREADYOUT
		&& !IRQ && !IRQ_VECTOR_REQ && GROUP_REQ == 8'h00 && !WAKE_PULSE) else $error("reset state wrong");
	upper_zero_a: assert property (HRDATA[31:8] == 24'h0 && !HRESP) else $error("upper bits set");
	read_wait_a: assert property (rd_go |=> rd_answer) else $error("read wait wrong");
	write_nowait_a: assert property (wr_go |=> HREADYOUT) else $error("write stalled");
	unmapped_zero_a: assert property (rd_zero(32'h34, 32'hFF, 8'h00)) else $error("unmapped read");
	group2_mask_a: assert property (rd_zero(32'h10, 32'h10, 8'h33)) else $error("group 2 bits");
	group5_mask_a: assert property (rd_zero(32'h1C, 32'h1C, 8'h33)) else $error("group 5 bits");
	group6_mask_a: assert property (rd_zero(32'h20, 32'h20, 8'h77)) else $error("group 6 bits");
	group7_mask_a: assert property (rd_zero(32'h24, 32'h24, 8'h77)) else $error("group 7 bits");
	ack_block_a: assert property (SERVICE_ACK |=> !IRQ_VECTOR_REQ [*2]) else $error("vector after ack");
endmodule

//--- verification/irq_flag_bank_tb.sv
// Purpose: Register and event tests of the interrupt flag bank
// Assumes: Bank read masks FF,FF,FF,FF,33,FF,FF,33,77,77
// Notes:   Event patterns are complements, catching swapped bits
`timescale 1ns/1ps
module irq_flag_bank_tb;
	logic        ref_clk = 0;
	logic        srst = 1;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic        ack = 0;
	logic [1:0]  g89 = 0;
	logic [27:0] fire = 0;
	logic [31:0] r;
	wire  [27:0] evt;
	wire  [31:0] hrdata;
	wire  [7:0]  greq;
	wire         hready, hresp, vec, wake, irq;
	int          fails = 0, checked = 0, wakes = 0, w0, i;
	// Expected bytes, bank index order
	logic [79:0] keep = 80'hFFFFFFFF33FFFF337777;
	logic [79:0] exp1 = 80'h0020A0A020A0A0206020;
	logic [79:0] exp2 = 80'h60105050105050101050;
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wake === 1'b1) wakes <= wakes + 1;
	event_source_model src (.clk(ref_clk), .fire(fire), .evt(evt));
	irq_flag_bank dut (.REF_CLK(ref_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .STD_TIMER_A_EVT(evt[2:0]), .STD_TIMER_P_EVT(evt[5:3]),
		.PER_TIMER_A_EVT(evt[11:6]), .PER_TIMER_P_EVT(evt[17:12]), .SERIAL_EVT(evt[18]), .SPI_EVT(evt[19]),
		.EEPROM_EVT(evt[20]), .LVD_EVT(evt[21]), .UART_EVT(evt[23:22]), .COMP_EVT(evt[25:24]),
		.EXT_PIN_EVT(evt[27:26]), .GROUP_8_9_REQ(g89), .SERVICE_ACK(ack), .IRQ_VECTOR_REQ(vec),
		.GROUP_REQ(greq), .WAKE_PULSE(wake), .IRQ(irq));
	task chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, want);
		end
	endtask
	// One AHB-Lite single word transfer
	task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		r = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk(r, {24'h0, e});
	endtask
	task pulse(input logic [27:0] v, input logic [1:0] g);
		@(posedge ref_clk);
		fire <= v;
		g89 <= g;
		@(posedge ref_clk);
		fire <= 28'h0;
		g89 <= 2'b00;
		repeat (3) @(posedge ref_clk);
	endtask
	// Clear top down, so group flags are not set again
	task clear_bank;
		for (i = 9; i >= 0; i--) xfer(8'(i * 4), 1'b1, 8'h00);
	endtask
	task close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge ref_clk);
		fails++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		for (i = 0; i < 13; i++) rd(8'(i * 4), 8'h00);
		for (i = 0; i < 10; i++) xfer(8'(i * 4), 1'b1, 8'hFF);
		for (i = 0; i < 10; i++) rd(8'(i * 4), keep[79 - 8 * i -: 8]);
		xfer(8'h34, 1'b1, 8'hFF);
		rd(8'h34, 8'h00);
		clear_bank;
		$display("test layout done");
		w0 = wakes;
		pulse(28'h9940FC7, 2'b00);
		for (i = 0; i < 10; i++) rd(8'(i * 4), exp1[79 - 8 * i -: 8]);
		chk(wakes != w0, 1);
		xfer(8'h14, 1'b1, 8'hA8);
		rd(8'h00, 8'h80);
		chk(greq, 8'h08);
		xfer(8'h00, 1'b1, 8'h88);
		repeat (2) @(posedge ref_clk);
		chk(vec, 0);
		xfer(8'h28, 1'b1, 8'h01);
		repeat (2) @(posedge ref_clk);
		chk(vec, 1);
		ack <= 1;
		@(posedge ref_clk);
		ack <= 0;
		repeat (2) @(posedge ref_clk);
		chk(vec, 0);
		rd(8'h28, 8'h00);
		chk(irq, 0);
		xfer(8'h30, 1'b1, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1);
		rd(8'h2C, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk(irq, 0);
		$display("test vector done");
		clear_bank;
		pulse(28'h66BF038, 2'b11);
		for (i = 0; i < 10; i++) rd(8'(i * 4), exp2[79 - 8 * i -: 8]);
		w0 = wakes;
		pulse(28'h66BF038, 2'b00);
		chk(wakes, w0);
		$display("test second pattern done");
		close_out;
	end
endmodule
bind irq_flag_bank irq_flag_bank_checker chk_i (.REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.SERVICE_ACK(SERVICE_ACK), .IRQ_VECTOR_REQ(IRQ_VECTOR_REQ), .GROUP_REQ(GROUP_REQ), .WAKE_PULSE(WAKE_PULSE),
	.IRQ(IRQ));
